//--- shared/ppc_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * pin controller. Assumes a 32-bit APB slave with one word per register.
 */
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// Register offsets inside one group window
`define PPC_OFF_DIR     7'h00
`define PPC_OFF_DIRECTION_CLEAR_STROBE  7'h04
`define PPC_OFF_DIRECTION_SET_STROBE  7'h08
`define PPC_OFF_DIRECTION_TOGGLE_STROBE  7'h0c
`define PPC_OFF_OUT     7'h10
`define PPC_OFF_LEVEL_CLEAR_STROBE  7'h14
`define PPC_OFF_LEVEL_SET_STROBE  7'h18
`define PPC_OFF_LEVEL_TOGGLE_STROBE  7'h1c
`define PPC_OFF_IN      7'h20
`define PPC_OFF_CTRL    7'h24
`define PPC_OFF_EVCTRL  7'h2c
`define PPC_OFF_FSEL    7'h30
`define PPC_OFF_PINCFG  7'h40
`define PPC_OFF_LAST    7'h5c
// Spacing between group windows, in bytes
`define PPC_GROUP_SPAN  8'h80
// Words of config memory per group: 4 select words, 8 config words
`define PPC_MEM_WORDS   12
`define PPC_MEM_CFGW    4

// Config byte fields
`define PPC_CFG_PMUX    0
`define PPC_CFG_INPUT_BUFFER_ENABLE    1
`define PPC_CFG_PULL    2
// Event control byte fields
`define PPC_EV_PID      0
`define PPC_EV_ACT      5
`define PPC_EV_EN       7

// Reset values
`define PPC_RST_DIR     32'h0000_0000
`define PPC_RST_OUT     32'h0000_0000
`define PPC_RST_CTRL    4'h0
`define PPC_RST_EVC     32'h0000_0000

// Timing: on-demand resync delay
`define PPC_CLK_NS      25
`define PPC_SYNC_NS     50
`define PPC_SYNC_CYC    ((`PPC_SYNC_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)

`endif

//--- shared/ppc_pkg.sv
/*
 * Types of the pin controller.
 * Assumes ppc_cfg.svh holds all numeric constants.
 */
package ppc_pkg;

	// Event action codes
	typedef enum logic [1:0] {
		PPC_EV_OUT = 2'h0,
		PPC_EV_SET = 2'h1,
		PPC_EV_CLR = 2'h2,
		PPC_EV_TGL = 2'h3
	} ppc_event_action_select_t;

endpackage : ppc_pkg

//--- shared/ppc_mem_if.sv
/*
 * Carrier between the controller and its config memory.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/10ps
interface ppc_mem_if #(parameter int WORDS = 24);
	localparam int AW = $clog2(WORDS);

	logic              wr_en;    // Word write strobe
	logic [AW-1:0]     wr_addr;  // Word written
	logic [3:0]        wr_be;    // Byte lanes written
	logic [31:0]       wr_data;  // Write data
	logic [AW-1:0]     rd_addr;  // Word read
	logic [31:0]       rd_data;  // Registered read data
	logic [WORDS*32-1:0] image;  // Whole contents, live

	modport ctl (output wr_en, wr_addr, wr_be, wr_data, rd_addr,
		input rd_data, image);
	modport mem (input wr_en, wr_addr, wr_be, wr_data, rd_addr,
		output rd_data, image);
endinterface : ppc_mem_if

//--- logic/ppc_cfg_mem.sv
/*
 * Byte-writable store of pin config and function-select bytes.
 * Assumes writes come one word at a time; read data lag address by one cycle.
 */
`timescale 1ns/10ps
module ppc_cfg_mem #(parameter int WORDS = 24) (
	input  wire logic pclk,
	input  wire logic presetn,
	ppc_mem_if.mem    m
);
	typedef struct packed {
		logic [WORDS*32-1:0] img;  // Stored words
		logic [31:0]         rd;   // Read register
	} ppc_mst_t;

	ppc_mst_t st;
	ppc_mst_t next_st;

	////////////////////////////////////////////////////////////////////////
	// Byte-lane writes and registered read
	always_comb begin
		next_st = st;
		for (int w = 0; w < WORDS; w++) begin
			for (int b = 0; b < 4; b++) begin
				if (m.wr_en && int'(m.wr_addr) == w && m.wr_be[b]) begin
					next_st.img[w*32+b*8 +: 8] = m.wr_data[b*8 +: 8];
				end
			end
		end
		// Out-of-range words read as zero
		next_st.rd = (int'(m.rd_addr) < WORDS) ? st.img[32*int'(m.rd_addr) +: 32] : 32'h0;
	end

	// Reset clears every byte: all pins on port control, buffers off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign m.rd_data = st.rd;
	assign m.image   = st.img;
endmodule : ppc_cfg_mem

//--- logic/ppc_port.sv
/*
 * General-purpose pin controller: per-group direction, level, sampling,
 * pin config, peripheral mux and event actions behind an APB slave.
 * Assumes pad and event inputs are synchronous to pclk and that the pad
 * cell resolves pad_out/pad_oe/pull signals into the wire.
 */
// Notes on behaviour
// RQ1: One register set per group, 0x80 apart
// RQ2: Pins 0..31 own bit y everywhere
// RQ3: Direction one is output, zero input
// RQ4: Output pin drives its level bit
// RQ5: Input register readable in any direction
// RQ6: Input enable zero stops sampling
// RQ7: Mux enable hands pin to selected peripheral
// RQ8: Reset tri-states pins, buffers off
// RQ9: Direction-set strobe sets written ones
// RQ10: Direction-clear strobe clears written ones
// RQ11: Level set, clear, toggle strobes
// RQ12: On-demand sampling adds two cycles
// RQ13: Continuous sampling bit per eight pins
// RQ14: Config byte at first offset plus y
// RQ15: Select byte at offset plus y/2
// RQ16: All zero disables every digital function
// RQ17: Input pull follows the level bit
// RQ18: Output disables pull
// RQ19: Output input buffer follows input enable
// RQ20: Four events set, clear, toggle, drive
// RQ21: Event actions land within three cycles
// RQ22: Simultaneous events merge into one action
// RQ23: Direction-toggle strobe, zeros no effect
// RQ24: Byte-lane writes, single atomic update
`timescale 1ns/10ps
`include "ppc_cfg.svh"
module ppc_port #(
	parameter int GROUPS = 2,   // Pin groups
	parameter int FUNCS  = 16,  // Peripheral functions per pin
	parameter int AW     = 8    // APB address width
) (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [AW-1:0]             paddr,
	input  wire logic [3:0]                pstrb,
	input  wire logic [31:0]               pwdata,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [GROUPS*32-1:0]      pad_in,
	output logic [GROUPS*32-1:0]           pad_out,
	output logic [GROUPS*32-1:0]           pad_oe,
	output logic [GROUPS*32-1:0]           pad_ie,
	output logic [GROUPS*32-1:0]           pad_pull_en,
	output logic [GROUPS*32-1:0]           pad_pull_up,
	input  wire logic [GROUPS*32*FUNCS-1:0] periph_dout,
	input  wire logic [GROUPS*32*FUNCS-1:0] periph_doe,
	output logic [GROUPS*32-1:0]           periph_din,
	input  wire logic [GROUPS*4-1:0]       ev_in
);
	localparam int N  = GROUPS * 32;             // All pins
	localparam int MW = GROUPS * `PPC_MEM_WORDS; // Config memory words

	////////////////////////////////////////////////////////////////////////
	// Parameter checks
	generate
		if (GROUPS < 1 || GROUPS * 128 > (1 << AW) || FUNCS < 1 || FUNCS > 16) begin : g_bad
			$error("ppc_port: unsupported GROUPS, FUNCS or AW");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [N-1:0]        dir;      // Direction, one is output
		logic [N-1:0]        out;      // Output level / pull sense
		logic [N-1:0]        s1;       // Resync stage one
		logic [N-1:0]        s2;       // Resync stage two, readable
		logic [N-1:0]        pad_out;  // Pad level
		logic [N-1:0]        pad_oe;   // Pad driver enable
		logic [N-1:0]        pad_ie;   // Pad input buffer enable
		logic [N-1:0]        pad_pe;   // Pad pull enable
		logic [N-1:0]        pad_pu;   // Pad pull direction
		logic [N-1:0]        pdin;     // Level to peripherals
		logic [GROUPS*4-1:0] samp;     // Continuous sampling per 8 pins
		logic [GROUPS*4-1:0] ev_prev;  // Event level last cycle
		logic [GROUPS*32-1:0] evc;     // Event control, a byte per event
		logic [1:0]          cnt;      // Access-phase wait count
		logic                pready;
		logic                pslverr;
		logic [31:0]         prdata;
	} ppc_st_t;

	ppc_st_t st;
	ppc_st_t next_st;

	ppc_mem_if #(.WORDS(MW)) mif ();

	ppc_cfg_mem #(.WORDS(MW)) u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.m       (mif.mem)
	);

	////////////////////////////////////////////////////////////////////////
	// Address decode
	logic [AW-8:0] grp;      // Group index from address
	logic [6:0]    off;      // Offset inside the group window
	logic          grp_ok;   // Group exists
	logic          is_mem;   // Config or select word
	logic          is_in;    // Input level register
	logic          hit;      // Mapped register
	logic [31:0]   bmask;    // Byte lanes as a bit mask
	logic          wr_done;  // Write takes effect this edge

	always_comb begin
		grp    = paddr[AW-1:7];                                          // RQ1
		off    = {paddr[6:2], 2'b00};
		grp_ok = int'(grp) < GROUPS;
		is_mem = off >= `PPC_OFF_FSEL && off <= `PPC_OFF_LAST;
		is_in  = off == `PPC_OFF_IN;
		hit    = grp_ok && (off <= `PPC_OFF_CTRL || off == `PPC_OFF_EVCTRL || is_mem);
		for (int b = 0; b < 4; b++) begin
			bmask[b*8 +: 8] = {8{pstrb[b]}};                             // RQ24
		end
		wr_done = psel && penable && st.pready && pwrite && hit;
	end

	// Config words: select bytes first, then one config byte per pin
	assign mif.rd_addr = ($clog2(MW))'(int'(grp) * `PPC_MEM_WORDS
		+ int'(off - `PPC_OFF_FSEL) / 4);                                // RQ14 RQ15
	assign mif.wr_addr = mif.rd_addr;
	assign mif.wr_en   = wr_done && is_mem;                              // RQ24
	assign mif.wr_be   = pstrb;
	assign mif.wr_data = pwdata;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [31:0] gd;      // Group direction
		logic [31:0] go;      // Group level
		logic [31:0] rdv;     // Read value
		logic [7:0]  cfg;     // Pin config byte
		logic [7:0]  evb;     // Event control byte
		logic [3:0]  fsel;    // Function select of a pin
		logic [1:0]  need;    // Wait cycles of this access
		logic        sen;     // Synchronizer clock enable
		logic        hs;      // Some event asks set
		logic        hc;      // Some event asks clear
		logic        ht;      // Some event asks toggle
		logic        dv;      // Event drives the pin directly
		logic        dl;      // Level of that event
		int          gi;
		int          p;
		gd   = '0;
		go   = '0;
		rdv  = '0;
		cfg  = '0;
		evb  = '0;
		fsel = '0;
		need = '0;
		sen  = 1'b0;
		hs   = 1'b0;
		hc   = 1'b0;
		ht   = 1'b0;
		dv   = 1'b0;
		dl   = 1'b0;
		gi   = grp_ok ? int'(grp) : 0;
		p    = 0;
		next_st = st;
		next_st.ev_prev = ev_in;

		// Read value of the addressed register
		gd = st.dir[gi*32 +: 32];
		go = st.out[gi*32 +: 32];
		if (is_mem) begin
			rdv = mif.rd_data;
		end else if (off <= `PPC_OFF_DIRECTION_TOGGLE_STROBE) begin
			rdv = gd;
		end else if (off <= `PPC_OFF_LEVEL_TOGGLE_STROBE) begin
			rdv = go;
		end else if (is_in) begin
			rdv = st.s2[gi*32 +: 32];                                    // RQ5
		end else if (off == `PPC_OFF_CTRL) begin
			rdv = {28'h0, st.samp[gi*4 +: 4]};
		end else if (off == `PPC_OFF_EVCTRL) begin
			rdv = st.evc[gi*32 +: 32];
		end
		if (!hit) begin
			rdv = '0;
		end

		// Memory data lag one cycle; on-demand input adds the resync delay
		if (is_mem) begin
			need = 2'h1;
		end else if (is_in && st.samp[gi*4 +: 4] != 4'hf) begin
			need = 2'(`PPC_SYNC_CYC);                                    // RQ12
		end

		// Access-phase wait count; answer registered at the end
		if (psel && penable && !st.pready) begin
			if (st.cnt == need) begin
				next_st.pready  = 1'b1;
				next_st.prdata  = rdv;
				next_st.pslverr = !hit;
			end else begin
				next_st.cnt = st.cnt + 2'h1;
			end
		end else begin
			next_st.pready  = 1'b0;
			next_st.pslverr = 1'b0;
			next_st.cnt     = 2'h0;
		end

		// Register writes; strobes touch only the ones written
		if (wr_done) begin
			unique case (off)
				`PPC_OFF_DIR:    gd = (gd & ~bmask) | (pwdata & bmask);
				`PPC_OFF_DIRECTION_CLEAR_STROBE: gd = gd & ~(pwdata & bmask);            // RQ10
				`PPC_OFF_DIRECTION_SET_STROBE: gd = gd | (pwdata & bmask);             // RQ9
				`PPC_OFF_DIRECTION_TOGGLE_STROBE: gd = gd ^ (pwdata & bmask);             // RQ23
				`PPC_OFF_OUT:    go = (go & ~bmask) | (pwdata & bmask);
				`PPC_OFF_LEVEL_CLEAR_STROBE: go = go & ~(pwdata & bmask);            // RQ11
				`PPC_OFF_LEVEL_SET_STROBE: go = go | (pwdata & bmask);             // RQ11
				`PPC_OFF_LEVEL_TOGGLE_STROBE: go = go ^ (pwdata & bmask);             // RQ11
				`PPC_OFF_CTRL: begin
					if (pstrb[0]) begin
						next_st.samp[gi*4 +: 4] = pwdata[3:0];           // RQ13
					end
				end
				`PPC_OFF_EVCTRL: begin
					next_st.evc[gi*32 +: 32] = (st.evc[gi*32 +: 32] & ~bmask)
						| (pwdata & bmask);
				end
				default: ;
			endcase
			next_st.dir[gi*32 +: 32] = gd;
			next_st.out[gi*32 +: 32] = go;
		end

		// Per pin: events, sampling, pad drive
		for (int g = 0; g < GROUPS; g++) begin
			for (int y = 0; y < 32; y++) begin
				p = g * 32 + y;                                          // RQ2
				cfg = mif.image[(g*`PPC_MEM_WORDS*4 + `PPC_MEM_CFGW*4 + y)*8 +: 8];
				fsel = mif.image[(g*`PPC_MEM_WORDS*4 + y/2)*8 + (y%2)*4 +: 4];
				hs = 1'b0;
				hc = 1'b0;
				ht = 1'b0;
				dv = 1'b0;
				dl = 1'b0;
				// Lowest event wins the direct drive, so scan downwards
				for (int e = 3; e >= 0; e--) begin
					evb = st.evc[g*32+e*8 +: 8];
					if (evb[`PPC_EV_EN] && int'(evb[`PPC_EV_PID +: 5]) == y) begin
						unique case (ppc_pkg::ppc_event_action_select_t'(evb[`PPC_EV_ACT +: 2]))
							ppc_pkg::PPC_EV_OUT: begin
								dv = 1'b1;                               // RQ20
								dl = ev_in[g*4+e];
							end
							ppc_pkg::PPC_EV_SET: hs = hs | (ev_in[g*4+e] & ~st.ev_prev[g*4+e]);
							ppc_pkg::PPC_EV_CLR: hc = hc | (ev_in[g*4+e] & ~st.ev_prev[g*4+e]);
							ppc_pkg::PPC_EV_TGL: ht = ht | (ev_in[g*4+e] & ~st.ev_prev[g*4+e]);
						endcase
					end
				end
				// One merged action, applied after any bus write
				if (hs && !hc && !ht) begin
					next_st.out[p] = 1'b1;                               // RQ21 RQ22
				end else if (hc && !hs && !ht) begin
					next_st.out[p] = 1'b0;                               // RQ22
				end else if (hs || hc || ht) begin
					next_st.out[p] = !next_st.out[p];                    // RQ22
				end

				// Resync only while enabled; a disabled buffer reads zero
				sen = st.samp[g*4 + y/8] || (psel && penable && !st.pready && !pwrite
					&& is_in && gi == g && grp_ok);                      // RQ12 RQ13
				if (!cfg[`PPC_CFG_INPUT_BUFFER_ENABLE]) begin
					next_st.s1[p] = 1'b0;                                // RQ6
					next_st.s2[p] = 1'b0;
				end else if (sen) begin
					next_st.s1[p] = pad_in[p];
					next_st.s2[p] = st.s1[p];
				end

				// Pad drive: peripheral when muxed, else the port
				if (cfg[`PPC_CFG_PMUX]) begin
					next_st.pad_oe[p]  = periph_doe[p*FUNCS + int'(fsel) % FUNCS]; // RQ7
					next_st.pad_out[p] = periph_dout[p*FUNCS + int'(fsel) % FUNCS];
				end else begin
					next_st.pad_oe[p]  = st.dir[p];                      // RQ3 RQ16
					next_st.pad_out[p] = st.dir[p] && (dv ? dl : st.out[p]); // RQ4
				end
				// Input buffer follows its enable in either direction
				next_st.pad_ie[p] = cfg[`PPC_CFG_INPUT_BUFFER_ENABLE];                  // RQ19
				// Pull only on an undriven port pin, sensed by the level bit
				next_st.pad_pe[p] = cfg[`PPC_CFG_PULL] && !st.dir[p]
					&& !cfg[`PPC_CFG_PMUX];                              // RQ17 RQ18
				next_st.pad_pu[p] = next_st.pad_pe[p] && st.out[p];      // RQ17
				next_st.pdin[p]   = pad_in[p] && cfg[`PPC_CFG_INPUT_BUFFER_ENABLE];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers; reset needs no clock to tri-state the pads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st      <= '0;                                               // RQ8
			st.dir  <= {GROUPS{`PPC_RST_DIR}};
			st.out  <= {GROUPS{`PPC_RST_OUT}};
			st.samp <= {GROUPS{`PPC_RST_CTRL}};
			st.evc  <= {GROUPS{`PPC_RST_EVC}};
		end else begin
			st <= next_st;
		end
	end

	assign prdata      = st.prdata;
	assign pready      = st.pready;
	assign pslverr     = st.pslverr;
	assign pad_out     = st.pad_out;
	assign pad_oe      = st.pad_oe;
	assign pad_ie      = st.pad_ie;
	assign pad_pull_en = st.pad_pe;
	assign pad_pull_up = st.pad_pu;
	assign periph_din  = st.pdin;

	////////////////////////////////////////////////////////////////////////
	// Checks on group 0, full-word writes; no_pull_a and reset_tri_a cover every pin
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic ev_quiet;  // No event edge anywhere this cycle
	assign ev_quiet = (ev_in & ~st.ev_prev) == '0;

	sequence wr_to(logic [6:0] o);
		psel && penable && st.pready && pwrite && paddr == AW'(o) && pstrb == 4'hf;
	endsequence

	sequence in_setup;
		psel && !penable && !pwrite && paddr == AW'(`PPC_OFF_IN);
	endsequence

	dir_set_a: assert property (wr_to(`PPC_OFF_DIRECTION_SET_STROBE) |=> // RQ9
		st.dir[31:0] == ($past(st.dir[31:0]) | $past(pwdata)))
		else $error("direction set strobe wrong");
	dir_clr_a: assert property (wr_to(`PPC_OFF_DIRECTION_CLEAR_STROBE) |=> // RQ10
		st.dir[31:0] == ($past(st.dir[31:0]) & ~$past(pwdata)))
		else $error("direction clear strobe wrong");
	dir_tgl_a: assert property (wr_to(`PPC_OFF_DIRECTION_TOGGLE_STROBE) |=> // RQ23
		st.dir[31:0] == ($past(st.dir[31:0]) ^ $past(pwdata)))
		else $error("direction toggle strobe wrong");
	out_set_a: assert property (wr_to(`PPC_OFF_LEVEL_SET_STROBE) and ev_quiet |=> // RQ11
		st.out[31:0] == ($past(st.out[31:0]) | $past(pwdata)))
		else $error("level set strobe wrong");
	pad_drive_a: assert property (st.dir[0] && !mif.image[`PPC_MEM_CFGW*32 + `PPC_CFG_PMUX]
		&& (st.evc[31:0] & 32'h8080_8080) == 32'h0 |=> // RQ4
		st.pad_oe[0] && st.pad_out[0] == $past(st.out[0]))
		else $error("output pin not driven from level bit");
	no_pull_a: assert property ((st.pad_oe & st.pad_pe) == '0) // RQ18
		else $error("pull enabled on a driven pin");
	in_wait_a: assert property ((in_setup and st.samp[3:0] != 4'hf) // RQ12
		##1 psel && penable |-> !st.pready [*3] ##1 st.pready)
		else $error("on-demand input read not two cycles late");
	in_fast_a: assert property ((in_setup and st.samp[3:0] == 4'hf) // RQ13
		##1 psel && penable |-> !st.pready ##1 st.pready)
		else $error("continuous input read delayed");
	input_buffer_enable_gate_a: assert property (!mif.image[`PPC_MEM_CFGW*32 + `PPC_CFG_INPUT_BUFFER_ENABLE] |=> // RQ6
		!st.s1[0] && !st.s2[0])
		else $error("disabled input still sampled");
	ev_set_a: assert property (ev_in[0] && !st.ev_prev[0] && st.evc[7:5] == 3'h5
		&& (ev_in[3:1] & ~st.ev_prev[3:1]) == 3'h0 |-> ##[1:3] st.out[st.evc[4:0]]) // RQ21
		else $error("set event not applied in time");
	reset_tri_a: assert property (disable iff (1'b0) $rose(presetn) |-> // RQ8
		st.pad_oe == '0 && st.pad_ie == '0 && st.pad_pe == '0)
		else $error("pads not tri-stated after reset");
endmodule : ppc_port

//--- dv/ppc_pad_model.sv
/*
 * External circuitry on the pins: a source per pin that the bench can switch
 * on, plus the pad wire itself. Assumes pad outputs are already registered.
 */
`timescale 1ns/10ps
module ppc_pad_model #(
	parameter int N = 64  // Pins modelled
) (
	input  wire logic         pclk,
	input  wire logic [N-1:0] pad_out,
	input  wire logic [N-1:0] pad_oe,
	input  wire logic [N-1:0] pad_pull_en,
	input  wire logic [N-1:0] pad_pull_up,
	input  wire logic [N-1:0] ext_en,
	input  wire logic [N-1:0] ext_val,
	output logic [N-1:0]      pad_in
);
	////////////////////////////////////////////////////////////////////////////
	logic flt = 1'b0;  // Level of an undriven, unpulled wire

	// A floating wire keeps changing, so a stale value never passes for a read
	always @(posedge pclk) begin
		flt <= ~flt;
	end

	// Device driver wins, then the external source, then the pull
	always_comb begin
		pad_in = (pad_oe & pad_out)
			| (~pad_oe & ext_en & ext_val)
			| (~pad_oe & ~ext_en & pad_pull_en & pad_pull_up)
			| (~pad_oe & ~ext_en & ~pad_pull_en & {N{flt}});
	end
endmodule : ppc_pad_model

//--- dv/gpio_pin_controller_tb.sv
/*
 * Self-checking bench of the pin controller over APB.
 * Assumes the pad model closes the loop from pad outputs back to pad_in.
 */
`timescale 1ns/10ps
`include "ppc_cfg.svh"
module gpio_pin_controller_tb;
	////////////////////////////////////////////////////////////////////////////
	logic           pclk = 1'b0;   // Port clock, 40 MHz
	logic           presetn = 1'b0;
	logic           psel = 1'b0;
	logic           penable = 1'b0;
	logic           pwrite = 1'b0;
	logic [7:0]     paddr = 8'h00;
	logic [3:0]     pstrb = 4'h0;
	logic [31:0]    pwdata = 32'h0;
	logic [31:0]    prdata;
	logic           pready;
	logic           pslverr;
	logic [63:0]    pad_in, pad_out, pad_oe, pad_ie, pad_pull_en, pad_pull_up;
	logic [1023:0]  periph_dout = '0;  // Peripheral levels
	logic [1023:0]  periph_doe = '0;   // Peripheral enables
	logic [63:0]    periph_din;
	logic [7:0]     ev_in = 8'h00;
	logic [63:0]    ext_en = '0;       // External source enables
	logic [63:0]    ext_val = '0;
	logic [31:0]    rdv;               // Last read data
	logic           err;               // Last error flag
	int             lat;               // Last access wait count
	int             failures = 0;
	int             n_checks = 0;

	always #12.5 pclk = ~pclk;

	ppc_port #(.GROUPS(2), .FUNCS(16), .AW(8)) ppc_port_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .pad_ie(pad_ie),
		.pad_pull_en(pad_pull_en), .pad_pull_up(pad_pull_up),
		.periph_dout(periph_dout), .periph_doe(periph_doe),
		.periph_din(periph_din), .ev_in(ev_in));

	ppc_pad_model #(.N(64)) ppc_pad_model_i (
		.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pull_en(pad_pull_en), .pad_pull_up(pad_pull_up),
		.ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

	////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task results();
		if (failures == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	// One comparison of a 32-bit result
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One APB transfer; waits for pready under a bound, keeps data and wait count
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		lat = i;
		rdv = prdata;
		err = pslverr;
		if (i == 20) begin
			failures++;
			results();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Full-word write and read shorthands
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hf);
	endtask : wr

	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0, 4'h0);
	endtask : rd

	////////////////////////////////////////////////////////////////////////////
	// Main sequence; pads are looked at two edges after a write lands
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		chk("reset pads", 32'h0, pad_oe[31:0] | pad_oe[63:32] | pad_ie[31:0] | pad_ie[63:32]
			| pad_pull_en[31:0] | pad_pull_en[63:32]);
		rd(`PPC_OFF_DIR);
		chk("dir reset", 32'h0, rdv);
		wr(`PPC_OFF_DIRECTION_SET_STROBE, 32'h8000_00f0);
		wr(`PPC_OFF_DIRECTION_CLEAR_STROBE, 32'h0000_0030);
		wr(`PPC_OFF_DIRECTION_TOGGLE_STROBE, 32'h0000_000f);
		rd(`PPC_OFF_DIR);
		chk("dir", 32'h8000_00cf, rdv);
		repeat (2) @(posedge pclk);
		chk("oe", 32'h8000_00cf, pad_oe[31:0]);
		wr(8'h80 | `PPC_OFF_DIRECTION_SET_STROBE, 32'h0000_0001);
		rd(8'h80 | `PPC_OFF_DIR);
		chk("dir g1", 32'h0000_0001, rdv);
		rd(`PPC_OFF_DIR);
		chk("dir g0", 32'h8000_00cf, rdv);
		wr(`PPC_OFF_LEVEL_SET_STROBE, 32'h0000_000f);
		wr(`PPC_OFF_LEVEL_CLEAR_STROBE, 32'h0000_0005);
		wr(`PPC_OFF_LEVEL_TOGGLE_STROBE, 32'h0000_0003);
		apb(1'b1, `PPC_OFF_LEVEL_SET_STROBE, 32'hffff_ffff, 4'h2);
		rd(`PPC_OFF_OUT);
		chk("out", 32'h0000_ff09, rdv);
		repeat (2) @(posedge pclk);
		chk("pad out", 32'h0000_0009, pad_out[31:0] & 32'h0000_000f);
		ext_en[10:8] <= 3'b111;
		ext_val[10:8] <= 3'b101;
		wr(`PPC_OFF_PINCFG + 8'h08, 32'h0400_0202);
		rd(`PPC_OFF_IN);
		chk("in demand", 32'h0000_0100, rdv);
		chk("in wait", 32'd3, lat);
		repeat (2) @(posedge pclk);
		chk("pull en", 32'h0000_0800, pad_pull_en[31:0]);
		chk("pull up", 32'h0000_0800, pad_pull_up[31:0] & 32'h0000_0800);
		chk("ie", 32'h0000_0300, pad_ie[31:0]);
		chk("off pin", 32'h0, (pad_oe[31:0] | pad_ie[31:0]) & 32'h0000_0400);
		chk("periph din", 32'h0000_0100, periph_din[31:0]);
		wr(`PPC_OFF_CTRL, 32'h0000_000f);
		rd(`PPC_OFF_IN);
		chk("in cont", 32'd1, lat);
		chk("in cont val", 32'h0000_0100, rdv);
		wr(`PPC_OFF_DIRECTION_SET_STROBE, 32'h0000_0900);
		wr(`PPC_OFF_LEVEL_CLEAR_STROBE, 32'h0000_0100);
		repeat (2) @(posedge pclk);
		rd(`PPC_OFF_IN);
		chk("in output", 32'h0000_0000, rdv);
		chk("ie output", 32'h0000_0300, pad_ie[31:0]);
		chk("pull output", 32'h0, pad_pull_en[31:0]);
		periph_dout[12 * 16 + 5] <= 1'b1;
		periph_doe[12 * 16 + 5] <= 1'b1;
		apb(1'b1, `PPC_OFF_FSEL + 8'h04, 32'h0005_0000, 4'h4);
		apb(1'b1, `PPC_OFF_PINCFG + 8'h0c, 32'h0000_0001, 4'h1);
		repeat (2) @(posedge pclk);
		chk("mux", 32'h0000_1000, pad_oe[31:0] & pad_out[31:0] & 32'h0000_1000);
		wr(`PPC_OFF_EVCTRL, 32'h81c3_a3a2);
		ev_in[3:0] <= 4'hf;
		repeat (4) @(posedge pclk);
		chk("ev pads", 32'h0000_0007, pad_out[31:0] & 32'h0000_000f);
		ev_in[3:0] <= 4'h0;
		repeat (2) @(posedge pclk);
		chk("ev drive", 32'h0, pad_out[31:0] & 32'h0000_0002);
		rd(`PPC_OFF_OUT);
		chk("ev out", 32'h0000_fe05, rdv);
		// Lone set event on a cleared pin: level bit, then pad, within the limit
		wr(`PPC_OFF_LEVEL_CLEAR_STROBE, 32'h0000_0004);
		ev_in[0] <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("ev set pad", 32'h0000_0004, pad_out[31:0] & 32'h0000_0004);
		rd(`PPC_OFF_OUT);
		chk("ev set out", 32'h0000_fe05, rdv);
		rd(8'h60);
		chk("unmapped", 32'h1, {31'h0, err});
		results();
	end
endmodule : gpio_pin_controller_tb
